//--- dcfifo_pkg.sv
/*
 * dcfifo_pkg: shared constants for the dual-clock flag-timing fifo.
 * assumes: one system clock aclk at 25 MHz; all pins sampled into it.
 */
`default_nettype none
package dcfifo_pkg;
   // register byte offsets
   localparam logic [7:0] DCFIFO_OFF_CTRL = 8'h00;
   localparam logic [7:0] DCFIFO_OFF_STAT = 8'h04;
   localparam logic [7:0] DCFIFO_OFF_IRQ_STAT = 8'h08;
   localparam logic [7:0] DCFIFO_OFF_IRQ_MASK = 8'h0c;
   localparam logic [7:0] DCFIFO_OFF_LEVEL = 8'h10;
   // control field positions
   localparam int DCFIFO_CTRL_WR_DDR = 0;
   localparam int DCFIFO_CTRL_RD_DDR = 1;
   localparam int DCFIFO_CTRL_FALL_THROUGH_MODE = 2;
   localparam int DCFIFO_CTRL_PRST = 3;
   localparam int DCFIFO_CTRL_AE_LSB = 8;
   localparam int DCFIFO_CTRL_AE_W = 8;
   // control reset value: sdr both ports, standard mode, offset 8
   localparam logic [31:0] DCFIFO_CTRL_RESET = 32'h0000_0800;
   // interrupt bit positions
   localparam int DCFIFO_IRQ_FULL = 0;
   localparam int DCFIFO_IRQ_EMPTY = 1;
   localparam int DCFIFO_IRQ_READY = 2;
   localparam int DCFIFO_IRQ_W = 3;
   // axi answers
   localparam logic [1:0] DCFIFO_RESP_OKAY = 2'h0;
   localparam logic [1:0] DCFIFO_RESP_SLVERR = 2'h2;
   // flag update delays, in cycles of the owning port clock
   localparam int DCFIFO_FULL_DLY = 1;
   localparam int DCFIFO_EMPTY_DLY = 1;
   localparam int DCFIFO_READY_DLY = 2;
   localparam int DCFIFO_AE_DLY = 1;
   // link clock period and the derived sampled-cycle figure
   localparam int DCFIFO_CLK_NS = 40;
   localparam int DCFIFO_LINK_NS = 320;
   localparam int DCFIFO_LINK_CYC = (DCFIFO_LINK_NS + DCFIFO_CLK_NS - 1) / DCFIFO_CLK_NS;
endpackage : dcfifo_pkg
`default_nettype wire

//--- dcfifo_edge.sv
/*
 * dcfifo_edge: two-flop synchroniser of a pin clock with rise and fall pulses.
 * assumes: the pin is asynchronous to aclk and slower than aclk/2.
 */
`timescale 1ns/1ps
`default_nettype none
module dcfifo_edge
(
   // system
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // pin and edges
   input wire logic pin,
   output logic level,
   output logic rise,
   output logic fall
);
   logic meta;
   logic sync;
   logic prev;

   // two flops, then a third for edge detection
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         meta <= 1'b0;
         sync <= 1'b0;
         prev <= 1'b0;
      end
      else if (ce)
      begin
         meta <= pin;
         sync <= meta;
         prev <= sync;
      end
   end

   // edges only from flops past the first
   assign level = sync;
   assign rise = ce & sync & ~prev;
   assign fall = ce & ~sync & prev;
endmodule : dcfifo_edge
`default_nettype wire

//--- dcfifo_mem.sv
/*
 * dcfifo_mem: storage array with one write and one read port.
 * assumes: caller never writes a full array nor reads an empty one.
 */
`timescale 1ns/1ps
`default_nettype none
module dcfifo_mem
#(
   parameter int WIDTH = 40,
   parameter int AW = 4
)
(
   // system
   input wire logic aclk,
   input wire logic ce,
   // write port
   input wire logic wen,
   input wire logic [AW-1:0] waddr,
   input wire logic [WIDTH-1:0] wdata,
   // read port
   input wire logic [AW-1:0] raddr,
   output logic [WIDTH-1:0] rdata
);
   logic [WIDTH-1:0] mem [0:(1<<AW)-1];

   // write on enable
   always_ff @(posedge aclk)
   begin
      if (ce && wen)
         mem[waddr] <= wdata;
   end

   // asynchronous read; the owner registers the output
   assign rdata = mem[raddr];
endmodule : dcfifo_mem
`default_nettype wire

//--- dcfifo_top.sv
/*
 * dcfifo_top: dual-clock fifo flag timing with an axi4-lite control port.
 * assumes: write and read clocks arrive as pins, sampled by aclk;
 * the writer and reader keep their clocks running.
 */
// Chosen here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - during master reset only output enable controls data drivers; select ignored
// - configuration pins are captured while master reset is held low
// - during partial reset only output enable controls data; select ignored
// - full flag clears one write clock after a read frees space
// - ddr read: free-space event taken from falling read clock edge
// - empty flag clears one read clock after a write into empty fifo
// - ddr write: write event taken from falling write clock edge
// - standard mode first word readable after skew, one read period, flag delay
// - fall-through mode: output ready goes low two read clocks after write
// - fall-through: almost-empty clears one read clock after level passes offset
// - fall-through depth is array size plus one output word
module dcfifo_top
import dcfifo_pkg::*;
#(
   parameter int WIDTH = 40,
   parameter int AW = 4
)
(
   // system
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // fifo pins
   input wire logic master_reset_n,
   input wire logic wclk,
   input wire logic write_select_n,
   input wire logic [WIDTH-1:0] wdata,
   input wire logic rclk,
   input wire logic read_select_n,
   input wire logic read_enable_n,
   input wire logic output_enable_n,
   input wire logic write_rate_sel,
   input wire logic read_rate_sel,
   input wire logic fall_through_mode,
   output logic [WIDTH-1:0] rdata,
   output logic rdata_oe_n,
   output logic full_flag_n,
   output logic empty_flag_n,
   output logic almost_empty_n,
   // axi4-lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // interrupt
   output logic irq
);
   import dcfifo_pkg::*;

   localparam int DEPTH = 1 << AW;

   // synchronised pin levels (two flops each)
   logic [8:0] pin_meta;
   logic [8:0] pin_sync;
   logic [WIDTH-1:0] wdata_meta;
   logic [WIDTH-1:0] wdata_sync;
   logic mrst_n;
   logic wsel_n;
   logic rsel_n;
   logic ren_n;
   logic oe_n;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pin_meta <= 9'h1ff;
         pin_sync <= 9'h1ff;
         wdata_meta <= '0;
         wdata_sync <= '0;
      end
      else if (ce)
      begin
         pin_meta <= {master_reset_n, write_select_n, read_select_n, read_enable_n, output_enable_n,
                      write_rate_sel, read_rate_sel, fall_through_mode, 1'b1};
         pin_sync <= pin_meta;
         wdata_meta <= wdata;
         wdata_sync <= wdata_meta;
      end
   end
   assign mrst_n = pin_sync[8];
   assign wsel_n = pin_sync[7];
   assign rsel_n = pin_sync[6];
   assign ren_n = pin_sync[5];
   assign oe_n = pin_sync[4];

   // port clock edges
   logic w_rise;
   logic w_fall;
   logic r_rise;
   logic r_fall;
   dcfifo_edge u_wedge (.aclk(aclk), .aresetn(aresetn), .ce(ce), .pin(wclk), .level(), .rise(w_rise), .fall(w_fall));
   dcfifo_edge u_redge (.aclk(aclk), .aresetn(aresetn), .ce(ce), .pin(rclk), .level(), .rise(r_rise), .fall(r_fall));

   // control register and configuration latched during master reset
   logic [31:0] ctrl;
   logic cfg_wddr;
   logic cfg_rddr;
   logic cfg_fall_through_mode;
   logic part_rst;
   logic in_reset;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cfg_wddr <= 1'b0;
         cfg_rddr <= 1'b0;
         cfg_fall_through_mode <= 1'b0;
      end
      else if (ce && !mrst_n)
      begin
         cfg_wddr <= pin_sync[3] | ctrl[DCFIFO_CTRL_WR_DDR];
         cfg_rddr <= pin_sync[2] | ctrl[DCFIFO_CTRL_RD_DDR];
         cfg_fall_through_mode <= pin_sync[1] | ctrl[DCFIFO_CTRL_FALL_THROUGH_MODE];
      end
   end
   assign part_rst = ctrl[DCFIFO_CTRL_PRST];
   assign in_reset = ~mrst_n | part_rst;

   // port events: ddr ports act on both edges, sampled edge already one skew late
   logic w_edge;
   logic r_edge;
   logic wr_do;
   logic rd_do;
   logic [AW:0] wptr;
   logic [AW:0] rptr;
   logic [AW:0] count;
   logic out_full;
   logic arr_empty;
   logic arr_full;
   assign w_edge = w_rise | (cfg_wddr & w_fall);
   assign r_edge = r_rise | (cfg_rddr & r_fall);
   assign count = wptr - rptr;
   assign arr_empty = (count == '0);
   assign arr_full = (count == DEPTH[AW:0]);
   assign wr_do = w_edge & ~wsel_n & ~arr_full & ~in_reset;
   // fall-through reads consume the output word; standard reads pop the array
   logic ft_load;
   logic ft_pop;
   logic std_pop;
   logic rsel_ok;
   assign ft_pop = cfg_fall_through_mode & r_edge & out_full & ~ren_n & rsel_ok;
   assign ft_load = cfg_fall_through_mode & r_edge & ~arr_empty & (~out_full | ft_pop);
   assign std_pop = ~cfg_fall_through_mode & r_edge & ~ren_n & rsel_ok & ~arr_empty;
   assign rd_do = (ft_load | std_pop) & ~in_reset;

   // pointers and output register
   logic [WIDTH-1:0] mem_q;
   dcfifo_mem #(.WIDTH(WIDTH), .AW(AW)) u_mem (.aclk(aclk), .ce(ce), .wen(wr_do), .waddr(wptr[AW-1:0]),
      .wdata(wdata_sync), .raddr(rptr[AW-1:0]), .rdata(mem_q));
   always_ff @(posedge aclk)
   begin
      if (!aresetn || in_reset)
      begin
         wptr <= '0;
         rptr <= '0;
         out_full <= 1'b0;
         rdata <= '0;
      end
      else if (ce)
      begin
         if (wr_do)
            wptr <= wptr + 1'b1;
         if (rd_do)
         begin
            rptr <= rptr + 1'b1;
            rdata <= mem_q;
         end
         if (rd_do && cfg_fall_through_mode)
            out_full <= 1'b1;
         else if (ft_pop)
            out_full <= 1'b0;
      end
   end

   // read select is ignored until the first read clock rise after any reset
   logic rsel_arm;
   always_ff @(posedge aclk)
   begin
      if (!aresetn || in_reset)
         rsel_arm <= 1'b0;
      else if (ce && r_rise)
         rsel_arm <= 1'b1;
   end
   assign rsel_ok = rsel_arm & ~rsel_n;

   // data driver enable: output enable alone during reset
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         rdata_oe_n <= 1'b1;
      else if (ce)
         rdata_oe_n <= in_reset ? oe_n : (oe_n | ~rsel_ok);
   end

   // flag pipelines: raw state stepped only on own port edge
   logic [AW+1:0] level;
   logic [DCFIFO_READY_DLY-1:0] ready_pipe;
   logic [DCFIFO_EMPTY_DLY-1:0] empty_pipe;
   logic [DCFIFO_AE_DLY-1:0] ae_pipe;
   logic [DCFIFO_FULL_DLY-1:0] full_pipe;
   logic [DCFIFO_CTRL_AE_W-1:0] ae_off;
   assign level = {1'b0, count} + {{(AW+1){1'b0}}, out_full};
   assign ae_off = ctrl[DCFIFO_CTRL_AE_LSB +: DCFIFO_CTRL_AE_W];
   always_ff @(posedge aclk)
   begin
      if (!aresetn || in_reset)
      begin
         full_pipe <= '1;
         empty_pipe <= '0;
         ready_pipe <= '1;
         ae_pipe <= '0;
      end
      else if (ce)
      begin
         if (w_rise)
            full_pipe <= DCFIFO_FULL_DLY'({full_pipe, ~arr_full});
         if (r_rise)
         begin
            empty_pipe <= DCFIFO_EMPTY_DLY'({empty_pipe, ~arr_empty});
            ready_pipe <= DCFIFO_READY_DLY'({ready_pipe, ~(~arr_empty | out_full)});
            ae_pipe <= DCFIFO_AE_DLY'({ae_pipe,
               ({{DCFIFO_CTRL_AE_W{1'b0}}, level} > {{(AW+2){1'b0}}, ae_off})});
         end
      end
   end

   // flag outputs from flops; fall-through uses output-ready on the empty pin
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         full_flag_n <= 1'b0;
         empty_flag_n <= 1'b0;
         almost_empty_n <= 1'b0;
      end
      else if (ce)
      begin
         full_flag_n <= full_pipe[DCFIFO_FULL_DLY-1];
         empty_flag_n <= cfg_fall_through_mode ? ready_pipe[DCFIFO_READY_DLY-1] : empty_pipe[DCFIFO_EMPTY_DLY-1];
         almost_empty_n <= ae_pipe[DCFIFO_AE_DLY-1];
      end
   end

   // interrupt events: full reached, empty cleared, output ready asserted
   logic [DCFIFO_IRQ_W-1:0] ev;
   logic [DCFIFO_IRQ_W-1:0] istat;
   logic [DCFIFO_IRQ_W-1:0] imask;
   logic full_q;
   logic empty_q;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         full_q <= 1'b0;
         empty_q <= 1'b0;
      end
      else if (ce)
      begin
         full_q <= full_flag_n;
         empty_q <= empty_flag_n;
      end
   end
   assign ev = {cfg_fall_through_mode & empty_q & ~empty_flag_n, ~cfg_fall_through_mode & ~empty_q & empty_flag_n, full_q & ~full_flag_n};

   // axi4-lite write path: address and data accepted in either order
   logic aw_hold;
   logic w_hold;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic do_write;
   logic wr_hit;
   assign do_write = aw_hold & w_hold & ~s_axi_bvalid;
   assign wr_hit = (aw_addr == DCFIFO_OFF_CTRL) | (aw_addr == DCFIFO_OFF_IRQ_STAT) | (aw_addr == DCFIFO_OFF_IRQ_MASK);
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_hold <= 1'b0;
         w_hold <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         w_strb <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= DCFIFO_RESP_OKAY;
      end
      else if (ce)
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_hold <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_hold <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write)
         begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? DCFIFO_RESP_OKAY : DCFIFO_RESP_SLVERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end
   assign s_axi_awready = ~aw_hold;
   assign s_axi_wready = ~w_hold;

   // register writes; hardware set beats a write-one clear
   logic [31:0] strb_mask;
   assign strb_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl <= DCFIFO_CTRL_RESET;
         imask <= '0;
         istat <= '0;
         irq <= 1'b0;
      end
      else if (ce)
      begin
         if (do_write && aw_addr == DCFIFO_OFF_CTRL)
            ctrl <= (ctrl & ~strb_mask) | (w_data & strb_mask);
         if (do_write && aw_addr == DCFIFO_OFF_IRQ_MASK && w_strb[0])
            imask <= w_data[DCFIFO_IRQ_W-1:0];
         if (do_write && aw_addr == DCFIFO_OFF_IRQ_STAT && w_strb[0])
            istat <= (istat & ~w_data[DCFIFO_IRQ_W-1:0]) | ev;
         else
            istat <= istat | ev;
         irq <= |(istat & imask);
      end
   end

   // axi4-lite read path, one cycle answer
   logic [31:0] rd_mux;
   logic rd_hit;
   assign rd_hit = (s_axi_araddr == DCFIFO_OFF_CTRL) | (s_axi_araddr == DCFIFO_OFF_STAT) |
                   (s_axi_araddr == DCFIFO_OFF_IRQ_STAT) | (s_axi_araddr == DCFIFO_OFF_IRQ_MASK) |
                   (s_axi_araddr == DCFIFO_OFF_LEVEL);
   assign rd_mux = (s_axi_araddr == DCFIFO_OFF_CTRL) ? ctrl :
                   (s_axi_araddr == DCFIFO_OFF_STAT) ? {25'h0, cfg_fall_through_mode, cfg_rddr, cfg_wddr, mrst_n,
                                                        almost_empty_n, empty_flag_n, full_flag_n} :
                   (s_axi_araddr == DCFIFO_OFF_IRQ_STAT) ? {{(32-DCFIFO_IRQ_W){1'b0}}, istat} :
                   (s_axi_araddr == DCFIFO_OFF_IRQ_MASK) ? {{(32-DCFIFO_IRQ_W){1'b0}}, imask} :
                   (s_axi_araddr == DCFIFO_OFF_LEVEL) ? {{(30-AW){1'b0}}, level} : 32'h0;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= DCFIFO_RESP_OKAY;
      end
      else if (ce)
      begin
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_hit ? DCFIFO_RESP_OKAY : DCFIFO_RESP_SLVERR;
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end
   assign s_axi_arready = ~s_axi_rvalid;
endmodule : dcfifo_top
`default_nettype wire

//--- dcfifo_props.sv
/*
 * dcfifo_props: port-level assertions for dcfifo_top, bound below.
 * assumes: one clock aclk, synchronous active-low reset aresetn.
 */
`timescale 1ns/1ps
`default_nettype none
module dcfifo_props
(
   // system
   input wire logic aclk,
   input wire logic aresetn,
   // fifo pins
   input wire logic master_reset_n,
   input wire logic wclk,
   input wire logic rclk,
   input wire logic output_enable_n,
   input wire logic fall_through_mode,
   input wire logic rdata_oe_n,
   input wire logic full_flag_n,
   input wire logic empty_flag_n,
   input wire logic almost_empty_n,
   // axi4-lite
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   logic wq, rq;
   logic [3:0] wc, rc;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // saturating count of aclk cycles since each port clock rose
   always_ff @(posedge aclk)
   begin
      wq <= wclk;
      rq <= rclk;
      wc <= (wclk && !wq) ? 4'h0 : wc + {3'h0, wc != 4'hf};
      rc <= (rclk && !rq) ? 4'h0 : rc + {3'h0, rc != 4'hf};
   end

   // axi answers come at once and stand until taken
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data not returned one cycle after address");
   a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped before rready");
   a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address accepted while data pending");
   a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before bready");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid)
      else $error("write response late");
   // full falls, empty (standard mode) and almost-empty rise only just after a rise of their own port clock
   a_full_on_wclk: assert property ($fell(full_flag_n) |-> wc inside {[2:6]})
      else $error("full flag changed away from a write clock rise");
   a_empty_on_rclk: assert property ($rose(empty_flag_n) && !fall_through_mode |-> rc inside {[2:6]})
      else $error("empty flag changed away from a read clock rise");
   a_ae_on_rclk: assert property ($rose(almost_empty_n) |-> rc inside {[2:6]})
      else $error("almost empty changed away from a read clock rise");
   // in master reset only output enable steers the data drivers
   a_oe_reset_on: assert property ((!master_reset_n && !output_enable_n)[*6] |-> !rdata_oe_n)
      else $error("data not driven in reset with output enable low");
   a_oe_reset_off: assert property ((!master_reset_n && output_enable_n)[*6] |-> rdata_oe_n)
      else $error("data driven in reset with output enable high");
endmodule : dcfifo_props

bind dcfifo_top dcfifo_props u_props
(
   .aclk, .aresetn, .master_reset_n, .wclk, .rclk, .output_enable_n, .fall_through_mode,
   .rdata_oe_n, .full_flag_n, .empty_flag_n, .almost_empty_n,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready
);
`default_nettype wire

//--- dcfifo_link.sv
/*
 * dcfifo_link: writer and reader on free-running port clocks.
 * assumes: aclk from the bench; 320 ns port clocks, phases unrelated.
 */
`timescale 1ns/1ps
`default_nettype none
module dcfifo_link
(
   // system
   input wire logic aclk,
   // writer side
   output var logic wclk,
   output var logic write_select_n,
   output var logic [39:0] wdata,
   // reader side
   output var logic rclk,
   output var logic read_enable_n
);
   // write clock never stops
   initial
   begin
      wclk = 1'b0;
      #13;
      forever #160 wclk = ~wclk;
   end

   // read clock never stops
   initial
   begin
      rclk = 1'b0;
      #97;
      forever #160 rclk = ~rclk;
   end

   // idle strobes
   initial
   begin
      write_select_n = 1'b1;
      read_enable_n = 1'b1;
      wdata = 40'h0;
   end

   // one word across one write clock rise
   task automatic push(input logic [39:0] d);
      @(negedge wclk);
      @(posedge aclk);
      write_select_n <= 1'b0;
      wdata <= d;
      @(negedge wclk);
      @(posedge aclk);
      write_select_n <= 1'b1;
      wdata <= ~d; // released bus shows no stale word
   endtask : push

   // one read strobe across one read clock rise
   task automatic pop();
      @(negedge rclk);
      @(posedge aclk);
      read_enable_n <= 1'b0;
      @(negedge rclk);
      @(posedge aclk);
      read_enable_n <= 1'b1;
   endtask : pop
endmodule : dcfifo_link
`default_nettype wire

//--- dcfifo_top_tb.sv
/*
 * dcfifo_top_tb: self-checking bench for dcfifo_top.
 * assumes: dcfifo_link drives the port clocks; checker bound by its own file.
 */
`timescale 1ns/1ps
`default_nettype none
module dcfifo_top_tb;
   import dcfifo_pkg::*;
   logic aclk, aresetn, ce, master_reset_n, read_select_n, output_enable_n;
   logic write_rate_sel, read_rate_sel, fall_through_mode, wclk, rclk, write_select_n, read_enable_n;
   logic rdata_oe_n, full_flag_n, empty_flag_n, almost_empty_n, irq;
   logic [39:0] wdata, rdata;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   int errors, checks_done;

   dcfifo_top u_dut (.*);
   dcfifo_link u_link (.aclk, .wclk, .write_select_n, .wdata, .rclk, .read_enable_n);

   // system clock
   initial
   begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   // verdict and end of run
   task final_report;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : final_report

   task automatic chk(input string n, input logic [39:0] s, input logic [39:0] e);
      checks_done++;
      if (s !== e)
      begin
         errors++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   function automatic logic flag(input int s);
      return (s == 0) ? empty_flag_n : (s == 1) ? full_flag_n : irq;
   endfunction : flag

   // bounded wait for a flag level
   task automatic wt(input int s, input logic v, input int lim);
      int n;
      n = 0;
      while (flag(s) !== v && n < lim)
      begin
         @(posedge aclk);
         n++;
      end
      chk($sformatf("flag %0d", s), flag(s), v);
      if (flag(s) !== v)
         final_report();
   endtask : wt

   // axi4-lite write, address and data offered together
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      n = 0;
      do
      begin
         @(posedge aclk);
         n++;
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid && n < 40);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      chk("write answer", s_axi_bvalid, 1'b1);
      if (!s_axi_bvalid)
         final_report();
   endtask : wr

   // axi4-lite read
   task automatic rd(input logic [7:0] a);
      int n;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      n = 0;
      do
      begin
         @(posedge aclk);
         n++;
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end
      while (!s_axi_rvalid && n < 40);
      rd_data = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      chk("read answer", s_axi_rvalid, 1'b1);
      if (!s_axi_rvalid)
         final_report();
   endtask : rd

   // master reset with configuration pins, then pins changed
   task automatic t_master(input logic w, input logic r, input logic f);
      @(posedge aclk);
      master_reset_n <= 1'b0;
      write_rate_sel <= w;
      read_rate_sel <= r;
      fall_through_mode <= f;
      read_select_n <= 1'b1;
      output_enable_n <= 1'b0;
      repeat (8) @(posedge aclk);
      chk("oe low in reset", rdata_oe_n, 1'b0);
      output_enable_n <= 1'b1;
      repeat (8) @(posedge aclk);
      chk("oe high in reset", rdata_oe_n, 1'b1);
      master_reset_n <= 1'b1;
      repeat (4) @(posedge aclk);
      write_rate_sel <= 1'b0;
      read_rate_sel <= 1'b0;
      read_select_n <= 1'b0;
      output_enable_n <= 1'b0;
      rd(DCFIFO_OFF_STAT);
      chk("latched config", rd_data[6:4], {f, r, w});
   endtask : t_master

   // registers: reset value and unmapped places
   task automatic t_regs();
      rd(DCFIFO_OFF_CTRL);
      chk("ctrl reset", rd_data, DCFIFO_CTRL_RESET);
      rd(8'h20);
      chk("unmapped read", {resp, rd_data}, {DCFIFO_RESP_SLVERR, 32'h0});
      wr(8'h20, 32'h1);
      chk("unmapped write", resp, DCFIFO_RESP_SLVERR);
   endtask : t_regs

   // standard mode: empty, fill past full, interrupt, drain in order
   task automatic t_fill();
      wr(DCFIFO_OFF_IRQ_MASK, 32'h0);
      wr(DCFIFO_OFF_IRQ_STAT, 32'h7);
      chk("empty idle", empty_flag_n, 1'b0);
      u_link.push(40'h1000);
      wt(0, 1'b1, 20);
      for (int i = 1; i < 16; i++)
         u_link.push(40'h1000 + i);
      wt(1, 1'b0, 20);
      u_link.push(40'hbad);
      chk("masked irq", irq, 1'b0);
      rd(DCFIFO_OFF_IRQ_STAT);
      chk("full event", rd_data[0], 1'b1);
      wr(DCFIFO_OFF_IRQ_MASK, 32'h1);
      wt(2, 1'b1, 4);
      wr(DCFIFO_OFF_IRQ_STAT, 32'h1);
      wt(2, 1'b0, 4);
      for (int i = 0; i < 16; i++)
      begin
         u_link.pop();
         if (i == 0)
            wt(1, 1'b1, 20);
         repeat (4) @(posedge aclk);
         chk("read word", rdata, 40'h1000 + i);
      end
      wt(0, 1'b0, 20);
   endtask : t_fill

   // partial reset: output enable alone steers data, fifo cleared
   task automatic t_partial();
      u_link.push(40'h77);
      wr(DCFIFO_OFF_CTRL, 32'h808);
      read_select_n <= 1'b1;
      repeat (8) @(posedge aclk);
      chk("oe low in partial", rdata_oe_n, 1'b0);
      chk("empty in partial", empty_flag_n, 1'b0);
      output_enable_n <= 1'b1;
      repeat (8) @(posedge aclk);
      chk("oe high in partial", rdata_oe_n, 1'b1);
      wr(DCFIFO_OFF_CTRL, 32'h800);
      read_select_n <= 1'b0;
      output_enable_n <= 1'b0;
      repeat (20) @(posedge aclk);
      chk("cleared", empty_flag_n, 1'b0);
   endtask : t_partial

   // fall-through: first word lands, depth is array plus one
   task automatic t_fall_through_mode();
      t_master(1'b0, 1'b1, 1'b1);
      u_link.push(40'h2000);
      repeat (30) @(posedge aclk);
      chk("fall through word", rdata, 40'h2000);
      chk("output ready", empty_flag_n, 1'b0);
      for (int i = 1; i < 16; i++)
         u_link.push(40'h2000 + i);
      repeat (8) @(posedge aclk);
      chk("not full at 16", full_flag_n, 1'b1);
      chk("almost empty clear", almost_empty_n, 1'b1);
      u_link.push(40'h2010);
      wt(1, 1'b0, 20);
   endtask : t_fall_through_mode

   // main sequence
   initial
   begin
      {aresetn, master_reset_n, read_select_n, output_enable_n} = 4'h7;
      {write_rate_sel, read_rate_sel, fall_through_mode, ce} = 4'h1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {16'h0, 32'h0, 4'hf};
      errors = 0;
      checks_done = 0;
      repeat (20) @(posedge aclk);
      chk("oe in reset", rdata_oe_n, 1'b1);
      aresetn <= 1'b1;
      t_master(1'b0, 1'b0, 1'b0);
      t_regs();
      t_fill();
      t_partial();
      t_fall_through_mode();
      final_report();
   end
endmodule : dcfifo_top_tb
`default_nettype wire
